//--- src/tm_pkg.sv
// What this block does
// (RULE_01) remote offsets held as 10-bit two's complement
// (RULE_02) first remote offset at 0x11 and 0x12
// (RULE_03) second remote offset at 0x34 and 0x35
// (RULE_04) config bit 3 redirects first offset to second
// (RULE_05) low byte top two bits; high byte sign
// (RULE_06) signed offset added to each remote result
// (RULE_07) offsets reset to zero
// (RULE_08) address and direction bit shifted in MSB first
// (RULE_09) acknowledge own address across ninth clock
// (RULE_10) direction 0 writes, 1 reads
// (RULE_11) byte is eight data bits plus acknowledge
// (RULE_12) data rising while clock high is stop
// (RULE_13) host ends read with nack then stop
// (RULE_14) writes one or two bytes, reads one byte
// (RULE_15) first write byte loads pointer, second stores
// (RULE_16) bit 5 at 0x22 masks local alerts
// (RULE_17) config bits 1 and 0 mask remotes
// (RULE_18) config bit 7 masks all; read 0x03, write 0x09
// (RULE_19) standby bit halts converter, drops pending result
// (RULE_20) write to 0x0F in standby runs one conversion
// (RULE_21) limit alerts still raised during standby
// (RULE_22) open comparator sampled at conversion start sets flags
// (RULE_23) flags sticky until read and condition gone
// (RULE_24) any unmasked flag drives active-low alert
`default_nettype none
package tm_pkg;
  // register pointer values
  localparam logic [7:0] REG_STATUS_FIRST   = 8'h02;
  localparam logic [7:0] REG_CFG_RD         = 8'h03;
  localparam logic [7:0] REG_CFG_WR         = 8'h09;
  localparam logic [7:0] REG_ONESHOT        = 8'h0F;
  localparam logic [7:0] REG_OFF_A_HIGH     = 8'h11;
  localparam logic [7:0] REG_OFF_A_LOW      = 8'h12;
  localparam logic [7:0] REG_CONSEC_ALERT   = 8'h22;
  localparam logic [7:0] REG_STATUS_SECOND  = 8'h23;
  localparam logic [7:0] REG_OFF_B_HIGH     = 8'h34;
  localparam logic [7:0] REG_OFF_B_LOW      = 8'h35;
  // reset values
  localparam logic [7:0] PTR_RESET          = 8'h00;
  localparam logic [7:0] CFG_RESET          = 8'h00;
  localparam logic [7:0] CONSEC_RESET       = 8'h00;
  localparam logic [9:0] OFFSET_RESET       = 10'h000;
  // field positions
  localparam int CFG_MASK_B_BIT     = 0;
  localparam int CFG_MASK_A_BIT     = 1;
  localparam int CFG_ALIAS_BIT      = 3;
  localparam int CFG_STANDBY_BIT    = 6;
  localparam int CFG_MASK_ALL_BIT   = 7;
  localparam int CONSEC_MASK_L_BIT  = 5;
  localparam int OFF_WIDTH          = 10;
  // converter channel codes
  localparam logic [1:0] CH_LOCAL = 2'h0;
  localparam logic [1:0] CH_A     = 2'h1;
  localparam logic [1:0] CH_B     = 2'h2;
  // own serial address, arbitrary value
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h4C;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACKA = 3'b010,
    ST_WR   = 3'b011,
    ST_ACKW = 3'b100,
    ST_RD   = 3'b101,
    ST_RACK = 3'b110,
    ST_SKIP = 3'b111
  } tm_state_e;
endpackage
`default_nettype wire

//--- src/tm_sync.sv
`default_nettype none
module tm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '1;
      sync_o <= '1;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- src/tm_ctrl.sv
`default_nettype none
module tm_ctrl #(
  parameter logic [6:0] DEV_ADDR = tm_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        serial_clock_i,
  input  wire logic        serial_data_line_i,
  output var  logic        serial_data_line_o,
  output var  logic        serial_data_line_oe_o,
  input  wire logic        open_a_i,
  input  wire logic        open_b_i,
  input  wire logic [5:0]  lim_flags_i,
  input  wire logic        conv_busy_i,
  input  wire logic        conv_start_i,
  input  wire logic        conv_done_i,
  input  wire logic [1:0]  conv_chan_i,
  input  wire logic [9:0]  conv_raw_i,
  output var  logic        conv_en_o,
  output var  logic        rep_valid_o,
  output var  logic [1:0]  rep_chan_o,
  output var  logic [10:0] rep_temp_o,
  output var  logic        alert_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [3:0]        sync_s;
  logic              scl_s;
  logic              sda_s;
  logic              opa_s;
  logic              opb_s;
  logic              scl_p_q;
  logic              sda_p_q;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  tm_pkg::tm_state_e st_q;
  logic [2:0]        cnt_q;
  logic [7:0]        sh_q;
  logic              rw_q;
  logic              ack_q;
  logic [1:0]        nbyte_q;
  logic              oe_q;
  logic [7:0]        ptr_q;
  logic              wr_en_q;
  logic [7:0]        wr_data_q;
  logic              rd_en_q;
  logic [7:0]        rd_data;
  logic [7:0]        byte_in;
  logic              addr_hit;
  logic [7:0]        cfg_q;
  logic [7:0]        consec_q;
  logic [9:0]        off_a_q;
  logic [9:0]        off_b_q;
  logic [5:0]        lim_q;
  logic              opa_q;
  logic              opb_q;
  logic              opa_now_q;
  logic              opb_now_q;
  logic              oneshot_q;
  logic              alert_any;
  logic [10:0]       sum_a;
  logic [10:0]       sum_b;
  logic              wr_off_a;
  logic              wr_off_b;
  logic              rd_st1;
  logic              rd_st2;

  tm_sync #(
    .W (4)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({serial_clock_i, serial_data_line_i, open_a_i, open_b_i}),
    .sync_o    (sync_s)
  );

  assign scl_s = sync_s[3];
  assign sda_s = sync_s[2];
  assign opa_s = sync_s[1];
  assign opb_s = sync_s[0];

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s; // RULE_12
  assign byte_in   = {sh_q[6:0], sda_s};
  assign addr_hit  = (sh_q[6:0] == DEV_ADDR);

  // register read mux; offset alias follows config bit 3
  always_comb
  begin
    rd_data = 8'h00;
    unique case (ptr_q)
      tm_pkg::REG_STATUS_FIRST:
        rd_data = {conv_busy_i, lim_q[5:2], opa_q, 2'b00};
      tm_pkg::REG_CFG_RD:
        rd_data = cfg_q;
      tm_pkg::REG_OFF_A_HIGH:
        rd_data = cfg_q[tm_pkg::CFG_ALIAS_BIT] ? off_b_q[9:2] : off_a_q[9:2]; // RULE_04
      tm_pkg::REG_OFF_A_LOW:
        rd_data = {cfg_q[tm_pkg::CFG_ALIAS_BIT] ? off_b_q[1:0] : off_a_q[1:0], 6'h00}; // RULE_05
      tm_pkg::REG_CONSEC_ALERT:
        rd_data = consec_q;
      tm_pkg::REG_STATUS_SECOND:
        rd_data = {3'b000, lim_q[1:0], opb_q, 1'b0, ~alert_n_o};
      tm_pkg::REG_OFF_B_HIGH:
        rd_data = off_b_q[9:2]; // RULE_03
      tm_pkg::REG_OFF_B_LOW:
        rd_data = {off_b_q[1:0], 6'h00};
      default:
        rd_data = 8'h00;
    endcase
  end

  // serial slave state machine
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_q      <= tm_pkg::ST_IDLE;
      cnt_q     <= 3'h0;
      sh_q      <= 8'h00;
      rw_q      <= 1'b0;
      ack_q     <= 1'b0;
      nbyte_q   <= 2'h0;
      oe_q      <= 1'b0;
      ptr_q     <= tm_pkg::PTR_RESET;
      wr_en_q   <= 1'b0;
      wr_data_q <= 8'h00;
      rd_en_q   <= 1'b0;
    end
    else
    begin
      wr_en_q <= 1'b0;
      rd_en_q <= 1'b0;
      if (stop_det)
      begin
        st_q <= tm_pkg::ST_IDLE;
        oe_q <= 1'b0;
      end
      else if (start_det)
      begin
        st_q  <= tm_pkg::ST_ADDR;
        cnt_q <= 3'h0;
        ack_q <= 1'b0;
        oe_q  <= 1'b0;
      end
      else
      begin
        unique case (st_q)
          tm_pkg::ST_IDLE, tm_pkg::ST_SKIP:
          begin
            oe_q <= 1'b0;
          end
          tm_pkg::ST_ADDR:
          begin
            if (scl_rise)
            begin
              sh_q  <= byte_in; // RULE_08
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7)
              begin
                rw_q <= sda_s; // RULE_10
                st_q <= addr_hit ? tm_pkg::ST_ACKA : tm_pkg::ST_SKIP; // RULE_09
              end
            end
          end
          tm_pkg::ST_ACKA:
          begin
            if (scl_fall)
            begin
              if (!ack_q)
              begin
                ack_q <= 1'b1;
                oe_q  <= 1'b1; // RULE_09
              end
              else
              begin
                ack_q   <= 1'b0;
                cnt_q   <= 3'h0;
                nbyte_q <= 2'h0;
                if (rw_q)
                begin
                  st_q    <= tm_pkg::ST_RD;
                  sh_q    <= rd_data;
                  oe_q    <= ~rd_data[7];
                  rd_en_q <= 1'b1;
                end
                else
                begin
                  st_q <= tm_pkg::ST_WR;
                  oe_q <= 1'b0;
                end
              end
            end
          end
          tm_pkg::ST_WR:
          begin
            if (scl_rise)
            begin
              sh_q  <= byte_in;
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) // RULE_11
              begin
                nbyte_q <= nbyte_q + 2'h1;
                if (nbyte_q == 2'h0)
                begin
                  ptr_q <= byte_in; // RULE_15
                  st_q  <= tm_pkg::ST_ACKW;
                end
                else if (nbyte_q == 2'h1)
                begin
                  wr_en_q   <= 1'b1; // RULE_15
                  wr_data_q <= byte_in;
                  st_q      <= tm_pkg::ST_ACKW;
                end
                else
                begin
                  st_q <= tm_pkg::ST_SKIP; // RULE_14
                end
              end
            end
          end
          tm_pkg::ST_ACKW:
          begin
            if (scl_fall)
            begin
              ack_q <= ~ack_q;
              oe_q  <= ~ack_q;
              if (ack_q)
              begin
                st_q  <= tm_pkg::ST_WR;
                cnt_q <= 3'h0;
              end
            end
          end
          tm_pkg::ST_RD:
          begin
            if (scl_rise)
            begin
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7)
              begin
                st_q <= tm_pkg::ST_RACK;
              end
            end
            else if (scl_fall)
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
          tm_pkg::ST_RACK:
          begin
            // single byte per read; host acknowledge ignored
            if (scl_fall)
            begin
              oe_q <= 1'b0;
              st_q <= tm_pkg::ST_SKIP; // RULE_14
            end
          end
        endcase
      end
    end
  end

  assign wr_off_a = ~cfg_q[tm_pkg::CFG_ALIAS_BIT];
  assign wr_off_b = cfg_q[tm_pkg::CFG_ALIAS_BIT];

  // software written registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_q    <= tm_pkg::CFG_RESET;
      consec_q <= tm_pkg::CONSEC_RESET;
      off_a_q  <= tm_pkg::OFFSET_RESET; // RULE_07
      off_b_q  <= tm_pkg::OFFSET_RESET;
    end
    else if (wr_en_q)
    begin
      unique case (ptr_q)
        tm_pkg::REG_CFG_WR:
          cfg_q <= wr_data_q;
        tm_pkg::REG_CONSEC_ALERT:
          consec_q <= wr_data_q;
        tm_pkg::REG_OFF_A_HIGH:
        begin
          if (wr_off_a)
            off_a_q[9:2] <= wr_data_q; // RULE_02
          if (wr_off_b)
            off_b_q[9:2] <= wr_data_q; // RULE_04
        end
        tm_pkg::REG_OFF_A_LOW:
        begin
          if (wr_off_a)
            off_a_q[1:0] <= wr_data_q[7:6]; // RULE_05
          if (wr_off_b)
            off_b_q[1:0] <= wr_data_q[7:6]; // RULE_04
        end
        tm_pkg::REG_OFF_B_HIGH:
          off_b_q[9:2] <= wr_data_q; // RULE_03
        tm_pkg::REG_OFF_B_LOW:
          off_b_q[1:0] <= wr_data_q[7:6]; // RULE_01
        default:
        begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  // one-shot request; setting wins over completion
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      oneshot_q <= 1'b0;
    else if (wr_en_q && ptr_q == tm_pkg::REG_ONESHOT && cfg_q[tm_pkg::CFG_STANDBY_BIT])
      oneshot_q <= 1'b1; // RULE_20
    else if (conv_done_i && conv_chan_i == tm_pkg::CH_B)
      oneshot_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      conv_en_o <= 1'b0;
    else
      conv_en_o <= ~cfg_q[tm_pkg::CFG_STANDBY_BIT] | oneshot_q; // RULE_19
  end

  assign sum_a = 11'({conv_raw_i[9], conv_raw_i} + {off_a_q[9], off_a_q});
  assign sum_b = 11'({conv_raw_i[9], conv_raw_i} + {off_b_q[9], off_b_q});

  // results reported only while the converter is allowed to run
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rep_valid_o <= 1'b0;
      rep_chan_o  <= tm_pkg::CH_LOCAL;
      rep_temp_o  <= 11'h000;
    end
    else
    begin
      rep_valid_o <= conv_done_i & conv_en_o; // RULE_19
      if (conv_done_i && conv_en_o)
      begin
        rep_chan_o <= conv_chan_i;
        if (conv_chan_i == tm_pkg::CH_A)
          rep_temp_o <= sum_a; // RULE_06
        else if (conv_chan_i == tm_pkg::CH_B)
          rep_temp_o <= sum_b; // RULE_06
        else
          rep_temp_o <= {conv_raw_i[9], conv_raw_i};
      end
    end
  end

  assign rd_st1 = rd_en_q && ptr_q == tm_pkg::REG_STATUS_FIRST;
  assign rd_st2 = rd_en_q && ptr_q == tm_pkg::REG_STATUS_SECOND;

  // sticky status flags, new events win over read clear
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lim_q     <= 6'h00;
      opa_q     <= 1'b0;
      opb_q     <= 1'b0;
      opa_now_q <= 1'b0;
      opb_now_q <= 1'b0;
    end
    else
    begin
      lim_q <= (lim_q & ~({{4{rd_st1}}, {2{rd_st2}}} & ~lim_flags_i)) | lim_flags_i; // RULE_21
      if (conv_start_i && conv_en_o)
      begin
        opa_now_q <= opa_s; // RULE_22
        opb_now_q <= opb_s;
      end
      opa_q <= (opa_q & ~(rd_st1 & ~opa_now_q)) | (conv_start_i & conv_en_o & opa_s); // RULE_23
      opb_q <= (opb_q & ~(rd_st2 & ~opb_now_q)) | (conv_start_i & conv_en_o & opb_s); // RULE_22
    end
  end

  assign alert_any = ~cfg_q[tm_pkg::CFG_MASK_ALL_BIT] & ( // RULE_18
    (|lim_q[5:4] & ~consec_q[tm_pkg::CONSEC_MASK_L_BIT]) | // RULE_16
    ((|lim_q[3:2] | opa_q) & ~cfg_q[tm_pkg::CFG_MASK_A_BIT]) | // RULE_17
    ((|lim_q[1:0] | opb_q) & ~cfg_q[tm_pkg::CFG_MASK_B_BIT]));

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      alert_n_o          <= 1'b1;
      serial_data_line_o <= 1'b0;
      serial_data_line_oe_o <= 1'b0;
    end
    else
    begin
      alert_n_o          <= ~alert_any; // RULE_24
      serial_data_line_o <= 1'b0;
      serial_data_line_oe_o <= oe_q;
    end
  end

  chk_offset_reset_zero: assert property ( // RULE_07
    $fell(sys_rst_i) |-> off_a_q == 10'h000 && off_b_q == 10'h000)
    else $error("offsets not zero after reset");

  chk_alias_write_target: assert property ( // RULE_04
    wr_en_q && ptr_q == tm_pkg::REG_OFF_A_HIGH && cfg_q[tm_pkg::CFG_ALIAS_BIT]
    |=> off_b_q[9:2] == $past(wr_data_q) && $stable(off_a_q))
    else $error("aliased offset write went to wrong channel");

  chk_offset_sum_report: assert property ( // RULE_06
    conv_done_i && conv_en_o && conv_chan_i == tm_pkg::CH_A
    |=> rep_valid_o && rep_temp_o == $past(sum_a))
    else $error("reported remote value lacks offset");

  chk_standby_drops_result: assert property ( // RULE_19
    conv_done_i && !conv_en_o |=> !rep_valid_o)
    else $error("result reported while halted");

  chk_open_flag_set: assert property ( // RULE_22
    conv_start_i && conv_en_o && opa_s |=> opa_q ##1 opa_q)
    else $error("open flag not set at conversion start");

  chk_mask_all_alert: assert property ( // RULE_18
    cfg_q[tm_pkg::CFG_MASK_ALL_BIT] |=> alert_n_o)
    else $error("alert asserted while all masked");

  chk_addr_ack_entry: assert property ( // RULE_09
    st_q == tm_pkg::ST_ADDR && scl_rise && cnt_q == 3'h7 && addr_hit && !start_det && !stop_det
    |=> st_q == tm_pkg::ST_ACKA)
    else $error("own address not acknowledged");

  chk_oneshot_arm: assert property ( // RULE_20
    wr_en_q && ptr_q == tm_pkg::REG_ONESHOT && cfg_q[tm_pkg::CFG_STANDBY_BIT]
    |=> oneshot_q ##2 conv_en_o)
    else $error("one-shot write did not enable converter");

  chk_flag_held_on_read: assert property ( // RULE_23
    rd_st1 |=> &(lim_q[5:2] | ~$past(lim_flags_i[5:2])))
    else $error("flag cleared while condition present");

  chk_pointer_load: assert property ( // RULE_15
    st_q == tm_pkg::ST_WR && scl_rise && cnt_q == 3'h7 && nbyte_q == 2'h0
    && !start_det && !stop_det |=> ptr_q == $past(byte_in))
    else $error("first write byte not loaded into pointer");
endmodule
`default_nettype wire

//--- verification/tm_host.sv
`default_nettype none
module tm_host (
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // quarter of a 125 ns bus bit; the clock stands high between frames
  localparam realtime Q = 31.25;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // nine pulses, data set only while the clock is low
  task automatic bit9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      #Q sda_low_o = ~tx[i];
      #Q scl_o = 1'b1;
      #Q rx[i] = sda_i;
      #Q scl_o = 1'b0;
    end
  endtask
  task automatic frame_open();
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask
  task automatic frame_close();
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #Q;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    input int n, output logic [3:0] nak);
    logic [8:0] r;
    nak = 4'h0;
    frame_open();
    bit9({a, 1'b0, 1'b1}, r);
    nak[0] = r[0];
    for (int k = 1; k <= n; k++)
    begin
      bit9({(k == 1) ? p : d, 1'b1}, r);
      nak[k] = r[0];
    end
    frame_close();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic nak);
    logic [8:0] r;
    frame_open();
    bit9({a, 1'b1, 1'b1}, r);
    nak = r[0];
    bit9(9'h1FF, r);
    d = r[8:1];
    frame_close();
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = tm_pkg::DEV_ADDR_DEFAULT;
  localparam logic [7:0] RST_REG [6] = '{8'h03, 8'h11, 8'h12, 8'h22, 8'h34, 8'h35};
  // mask register, mask value, limit bit, status register, status on read
  localparam logic [7:0] MREG [4] = '{8'h22, 8'h09, 8'h09, 8'h09};
  localparam logic [7:0] MVAL [4] = '{8'h20, 8'h02, 8'h01, 8'h80};
  localparam int         LBIT [4] = '{5, 3, 1, 4};
  localparam logic [7:0] SREG [4] = '{8'h02, 8'h02, 8'h23, 8'h02};
  localparam logic [7:0] SVAL [4] = '{8'h40, 8'h10, 8'h11, 8'h20};
  logic        clk_i, sys_rst_i, scl, sda, sda_low, data_o, oe;
  logic        open_a, open_b, busy, start, done, en, rep_valid, alert_n;
  logic [1:0]  chan, rep_chan;
  logic [5:0]  lim;
  logic [9:0]  raw;
  logic [10:0] rep_temp;
  logic [3:0]  nk;
  int          fails;
  int          checks;
  // open drain line with pull-up
  assign sda = ~(sda_low | (oe & ~data_o));
  tm_host u_tm_host (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  tm_ctrl u_tm_ctrl (
    .clk_i                 (clk_i),
    .sys_rst_i             (sys_rst_i),
    .serial_clock_i        (scl),
    .serial_data_line_i    (sda),
    .serial_data_line_o    (data_o),
    .serial_data_line_oe_o (oe),
    .open_a_i              (open_a),
    .open_b_i              (open_b),
    .lim_flags_i           (lim),
    .conv_busy_i           (busy),
    .conv_start_i          (start),
    .conv_done_i           (done),
    .conv_chan_i           (chan),
    .conv_raw_i            (raw),
    .conv_en_o             (en),
    .rep_valid_o           (rep_valid),
    .rep_chan_o            (rep_chan),
    .rep_temp_o            (rep_temp),
    .alert_n_o             (alert_n)
  );
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    u_tm_host.wr(ADDR, p, d, 2, nk);
    cmp(11'(nk), 11'h000, "write acks");
  endtask
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    u_tm_host.wr(ADDR, p, 8'h00, 1, nk);
    u_tm_host.rd(ADDR, d, nk[3]);
    cmp(11'(nk), 11'h000, "read acks");
    cmp(11'(d), 11'(e), "read data");
  endtask
  task automatic conv(input logic [1:0] c, input logic [9:0] r, input logic ev,
                      input logic [10:0] e);
    logic        seen;
    logic [1:0]  ch;
    logic [10:0] t;
    seen = 1'b0;
    ch = 2'h0;
    t = 11'h000;
    @(negedge clk_i);
    chan = c;
    raw = r;
    done = 1'b1;
    @(negedge clk_i);
    done = 1'b0;
    repeat (3)
    begin
      if (rep_valid === 1'b1)
      begin
        seen = 1'b1;
        ch = rep_chan;
        t = rep_temp;
      end
      @(negedge clk_i);
    end
    cmp(11'(seen), 11'(ev), "report seen");
    if (ev)
    begin
      cmp(11'(ch), 11'(c), "report chan");
      cmp(t, e, "report value");
    end
  endtask
  task automatic trip(input int b);
    @(negedge clk_i);
    lim[b] = 1'b1;
    @(negedge clk_i);
    lim[b] = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic pulse_start();
    repeat (4) @(negedge clk_i);
    start = 1'b1;
    @(negedge clk_i);
    start = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #1_000_000;
    fails++;
    test_done();
  end
  initial
  begin
    fails = 0;
    checks = 0;
    {open_a, open_b, busy, start, done} = 5'h00;
    chan = 2'h0;
    raw = 10'h000;
    lim = 6'h00;
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (8) @(negedge clk_i);
    cmp(11'(en), 11'h001, "enable after reset");
    cmp(11'(alert_n), 11'h001, "alert after reset");
    foreach (RST_REG[i]) rreg(RST_REG[i], 8'h00);
    $display("test reset done");
    wreg(8'h11, 8'h7F);
    wreg(8'h12, 8'hFF);
    rreg(8'h12, 8'hC0);
    rreg(8'h11, 8'h7F);
    wreg(8'h34, 8'h80);
    wreg(8'h35, 8'h80);
    rreg(8'h34, 8'h80);
    wreg(8'h09, 8'h08);
    rreg(8'h11, 8'h80);
    wreg(8'h12, 8'h40);
    rreg(8'h35, 8'h40);
    wreg(8'h09, 8'h00);
    rreg(8'h12, 8'hC0);
    conv(tm_pkg::CH_A, 10'h004, 1'b1, 11'h203);
    conv(tm_pkg::CH_B, 10'h004, 1'b1, 11'h605);
    conv(tm_pkg::CH_LOCAL, 10'h3FF, 1'b1, 11'h7FF);
    $display("test offsets done");
    u_tm_host.wr(ADDR ^ 7'h01, 8'h22, 8'hFF, 2, nk);
    cmp(11'(nk), 11'h007, "foreign address");
    u_tm_host.wr(ADDR, 8'h22, 8'h20, 3, nk);
    cmp(11'(nk), 11'h008, "third byte");
    rreg(8'h22, 8'h20);
    wreg(8'h03, 8'hFF);
    rreg(8'h03, 8'h00);
    wreg(8'h40, 8'h55);
    rreg(8'h40, 8'h00);
    $display("test protocol done");
    for (int k = 0; k < 4; k++)
    begin
      wreg(MREG[k], MVAL[k]);
      trip(LBIT[k]);
      cmp(11'(alert_n), 11'h001, "masked alert");
      wreg(MREG[k], 8'h00);
      cmp(11'(alert_n), 11'h000, "unmasked alert");
      rreg(SREG[k], SVAL[k]);
      cmp(11'(alert_n), 11'h001, "alert cleared");
    end
    @(negedge clk_i);
    lim[2] = 1'b1;
    busy = 1'b1;
    rreg(8'h02, 8'h88);
    @(negedge clk_i);
    busy = 1'b0;
    rreg(8'h02, 8'h08);
    @(negedge clk_i);
    lim[2] = 1'b0;
    rreg(8'h02, 8'h08);
    rreg(8'h02, 8'h00);
    $display("test alerts done");
    wreg(8'h09, 8'h40);
    cmp(11'(en), 11'h000, "standby halt");
    rreg(8'h03, 8'h40);
    conv(tm_pkg::CH_A, 10'h010, 1'b0, 11'h000);
    trip(0);
    cmp(11'(alert_n), 11'h000, "standby alert");
    rreg(8'h23, 8'h09);
    wreg(8'h0F, 8'hA5);
    cmp(11'(en), 11'h001, "one shot run");
    conv(tm_pkg::CH_B, 10'h004, 1'b1, 11'h605);
    cmp(11'(en), 11'h000, "back to standby");
    wreg(8'h09, 8'h00);
    $display("test standby done");
    @(negedge clk_i);
    open_a = 1'b1;
    open_b = 1'b1;
    pulse_start();
    cmp(11'(alert_n), 11'h000, "open alert");
    @(negedge clk_i);
    open_a = 1'b0;
    open_b = 1'b0;
    pulse_start();
    rreg(8'h02, 8'h04);
    rreg(8'h23, 8'h05);
    cmp(11'(alert_n), 11'h001, "open cleared");
    $display("test open circuit done");
    test_done();
  end
endmodule
`default_nettype wire
